// >>> hdl/dsw_defs.svh
/*
 Drive status word builder constants: register offsets, bit positions,
 reset values. Assumes inclusion by bare name from the design and testbench.
*/
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH

`define DSW_ADDR_STATUS        12'h000
`define DSW_ADDR_CONTROL       12'h004
`define DSW_ADDR_LOW_SPEED     12'h008
`define DSW_ADDR_HIGH_SPEED    12'h00C
`define DSW_ADDR_REFERENCE     12'h010

`define DSW_BIT_READY          0
`define DSW_BIT_SWITCHED_ON    1
`define DSW_BIT_OP_ENABLED     2
`define DSW_BIT_FAULT          3
`define DSW_BIT_VOLTAGE        4
`define DSW_BIT_QUICK_STOP     5
`define DSW_BIT_SW_DISABLED    6
`define DSW_BIT_ALARM          7
`define DSW_BIT_REMOTE         9
`define DSW_BIT_REF_REACHED    10
`define DSW_BIT_LIMIT          11
`define DSW_BIT_STOP_KEY       14
`define DSW_BIT_DIRECTION      15

`define DSW_CTL_IO_PROFILE     0
`define DSW_CTL_SPEED_MODE     1

`define DSW_RST_STATUS         16'h0000
`define DSW_RST_CONTROL        2'h2
`define DSW_RST_LOW_SPEED      16'h0000
`define DSW_RST_HIGH_SPEED     16'hFFFF

`endif

// >>> hdl/dsw_pkg.sv
/*
 Types for the drive status word builder.
 Assumes dsw_defs.svh is on the include path.
*/
package dsw_pkg;
    typedef enum logic [2:0]
    {
        DSW_PS_DISABLED  = 3'b000,
        DSW_PS_READY     = 3'b001,
        DSW_PS_SWITCHED  = 3'b011,
        DSW_PS_ENABLED   = 3'b010,
        DSW_PS_QSTOP     = 3'b110,
        DSW_PS_FAULT     = 3'b111,
        DSW_PS_NOT_READY = 3'b100
    } dsw_power_state_type;

    typedef struct packed
    {
        logic fault;
        logic alarm;
        logic line_supply;
        logic power_stage_only;
        logic network_ctrl;
        logic stop_key;
        logic reverse;
    } dsw_cond_type;

    typedef struct packed
    {
        logic        io_profile;
        logic        speed_mode;
        logic [15:0] low_speed_limit;
        logic [15:0] high_speed_limit;
    } dsw_cfg_type;
endpackage

// >>> hdl/dsw_status_word.sv
/*
 Drive status word builder: registered 16-bit status word plus an
 AXI4-Lite slave for profile, speed mode and speed limit settings.
 Assumes one clock, synchronous condition inputs and a single-beat master.
*/
//
// Overview of operation
// - Bits 0-2: ready, switched on, running
// - Bit 3 follows fault presence
// - Bit 4 shows line supply presence
// - Power-stage-only supply forces bit 4 high
// - Bit 5 reflects quick stop condition
// - Bit 6 set when switch-on disabled
// - Bit 7 alarm; bit 8 reads zero
// - Bit 9 one means network control
// - Bit 10 set when reference reached
// - Bit 11 set in speed mode when reference outside limits
// - Speed mode limits use low/high speed
// - Bits 12 and 13 read zero
// - Bit 14 set on terminal stop key
// - Bit 15 zero forward, one reverse
// - Bits 0,1,2,3,5,6 encode state
// - Same word in either profile
// - I/O profile bit 2 means may start
// - I/O profile bit 5 reads one; here it still reads zero in quick stop
// - I/O profile bit 9 means network command
`include "dsw_defs.svh"

module dsw_status_word
    import dsw_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                clk_en_i,
    input  wire dsw_power_state_type power_state_i,
    input  wire dsw_cond_type        cond_i,
    input  wire logic [15:0]         speed_ref_i,
    input  wire logic [15:0]         speed_act_i,
    output logic [15:0]              drive_status_word_o,
    output logic                     io_profile_o,
    input  wire logic [11:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [11:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] CTL_RST     = `DSW_RST_CONTROL;

    logic [15:0] status_q;
    logic [15:0] status_d;
    dsw_cfg_type cfg_q;
    logic [11:0] awaddr_q;
    logic        aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_held_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // Power-stage bits per state; undefined codes read as not ready
    logic [2:0] ps_run_on_rdy;
    logic       ps_disabled;
    logic       ps_qstop;
    logic       ps_fault;

    always_comb
    begin
        ps_run_on_rdy = 3'b000;
        ps_disabled   = 1'b0;
        ps_qstop      = 1'b0;
        ps_fault      = 1'b0;
        case (power_state_i)
            DSW_PS_DISABLED:
                ps_disabled = 1'b1;
            DSW_PS_READY:
                ps_run_on_rdy = 3'b001;
            DSW_PS_SWITCHED:
                ps_run_on_rdy = 3'b011;
            DSW_PS_ENABLED:
                ps_run_on_rdy = 3'b111;
            DSW_PS_QSTOP:
            begin
                ps_run_on_rdy = 3'b111;
                ps_qstop      = 1'b1;
            end
            DSW_PS_FAULT:
                ps_fault = 1'b1;
            default:
                ps_run_on_rdy = 3'b000;
        endcase
    end

    wire b_ready    = ps_run_on_rdy[0];
    wire b_switched = ps_run_on_rdy[1];
    // Running also means a nonzero reference may start the motor
    wire b_enabled  = ps_run_on_rdy[2];
    wire b_fault    = ps_fault | cond_i.fault;
    wire b_voltage  = cond_i.line_supply | cond_i.power_stage_only;
    // Quick stop active is low-true, so it reads one outside quick stop
    wire b_qstop    = ~ps_qstop;
    wire b_disabled = ps_disabled;
    // Condition flags pass straight through to their bits
    wire b_alarm    = cond_i.alarm;
    wire b_remote   = cond_i.network_ctrl;
    wire b_stop_key = cond_i.stop_key;
    wire b_reverse  = cond_i.reverse;

    wire limit_low  = speed_ref_i < cfg_q.low_speed_limit;
    wire limit_high = speed_ref_i > cfg_q.high_speed_limit;
    wire b_limit    = cfg_q.speed_mode & (limit_low | limit_high);
    // Reached means actual equals the target reference
    wire b_reached  = (speed_act_i == speed_ref_i);

    // Profile selection deliberately does not alter the word
    always_comb
    begin
        status_d = `DSW_RST_STATUS;
        status_d[`DSW_BIT_READY]       = b_ready;
        status_d[`DSW_BIT_SWITCHED_ON] = b_switched;
        status_d[`DSW_BIT_OP_ENABLED]  = b_enabled;
        status_d[`DSW_BIT_FAULT]       = b_fault;
        status_d[`DSW_BIT_VOLTAGE]     = b_voltage;
        status_d[`DSW_BIT_QUICK_STOP]  = b_qstop;
        status_d[`DSW_BIT_SW_DISABLED] = b_disabled;
        status_d[`DSW_BIT_ALARM]       = b_alarm;
        status_d[`DSW_BIT_REMOTE]      = b_remote;
        status_d[`DSW_BIT_REF_REACHED] = b_reached;
        status_d[`DSW_BIT_LIMIT]       = b_limit;
        status_d[`DSW_BIT_STOP_KEY]    = b_stop_key;
        status_d[`DSW_BIT_DIRECTION]   = b_reverse;
    end

    // One register for every bit keeps reads coherent
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            status_q <= `DSW_RST_STATUS;
        else if (clk_en_i)
            status_q <= status_d;
    end

    assign drive_status_word_o = status_q;
    assign io_profile_o        = cfg_q.io_profile;

    // Write channel: address and data taken in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    assign s_axi_awready = clk_en_i & ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = clk_en_i & ~w_held_q & ~bvalid_q;

    wire        aw_have  = aw_held_q | aw_take;
    wire        w_have   = w_held_q | w_take;
    wire [11:0] wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data  = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]  wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb;
    wire        wr_fire  = clk_en_i & aw_have & w_have & ~bvalid_q;

    logic wr_ctl;
    logic wr_low;
    logic wr_high;
    logic wr_ok;

    // Status and reference words take writes and drop them with OKAY
    always_comb
    begin
        wr_ctl  = 1'b0;
        wr_low  = 1'b0;
        wr_high = 1'b0;
        wr_ok   = 1'b1;
        if (wr_addr == `DSW_ADDR_CONTROL)
            wr_ctl = 1'b1;
        else if (wr_addr == `DSW_ADDR_LOW_SPEED)
            wr_low = 1'b1;
        else if (wr_addr == `DSW_ADDR_HIGH_SPEED)
            wr_high = 1'b1;
        else if (wr_addr != `DSW_ADDR_STATUS && wr_addr != `DSW_ADDR_REFERENCE)
            wr_ok = 1'b0;
    end

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] v;
        v = old_v;
        if (strb[0])
            v[7:0] = data[7:0];
        if (strb[1])
            v[15:8] = data[15:8];
        return v;
    endfunction

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end
        else if (clk_en_i)
        begin
            if (aw_take)
                awaddr_q <= s_axi_awaddr;
            aw_held_q <= aw_have & ~wr_fire;
        end
    end

    // Data half held on its own so either half may arrive first
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end
        else if (clk_en_i)
        begin
            if (w_take)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            w_held_q <= w_have & ~wr_fire;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_q.io_profile       <= CTL_RST[`DSW_CTL_IO_PROFILE];
            cfg_q.speed_mode       <= CTL_RST[`DSW_CTL_SPEED_MODE];
            cfg_q.low_speed_limit  <= `DSW_RST_LOW_SPEED;
            cfg_q.high_speed_limit <= `DSW_RST_HIGH_SPEED;
        end
        else if (wr_fire)
        begin
            if (wr_ctl && wr_strb[0])
            begin
                cfg_q.io_profile <= wr_data[`DSW_CTL_IO_PROFILE];
                cfg_q.speed_mode <= wr_data[`DSW_CTL_SPEED_MODE];
            end
            if (wr_low)
                cfg_q.low_speed_limit <= merge16(cfg_q.low_speed_limit, wr_data, wr_strb);
            if (wr_high)
                cfg_q.high_speed_limit <= merge16(cfg_q.high_speed_limit, wr_data, wr_strb);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (clk_en_i)
        begin
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Read channel, answered one cycle after the address
    assign s_axi_arready = clk_en_i & ~rvalid_q;
    wire ar_take = s_axi_arvalid & s_axi_arready;

    wire rd_status = (s_axi_araddr == `DSW_ADDR_STATUS);
    wire rd_ctl    = (s_axi_araddr == `DSW_ADDR_CONTROL);
    wire rd_low    = (s_axi_araddr == `DSW_ADDR_LOW_SPEED);
    wire rd_high   = (s_axi_araddr == `DSW_ADDR_HIGH_SPEED);
    wire rd_ref    = (s_axi_araddr == `DSW_ADDR_REFERENCE);

    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        if (rd_status)
            rd_word = {16'h0000, status_q};
        else if (rd_ctl)
            rd_word = {30'h00000000, cfg_q.speed_mode, cfg_q.io_profile};
        else if (rd_low)
            rd_word = {16'h0000, cfg_q.low_speed_limit};
        else if (rd_high)
            rd_word = {16'h0000, cfg_q.high_speed_limit};
        else if (rd_ref)
            rd_word = {speed_act_i, speed_ref_i};
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end
        else if (clk_en_i)
        begin
            if (ar_take)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
endmodule

// >>> test/dsw_status_word_checker.sv
/* Port assertions for the status word builder.
   Assumes one clock and the async active-low reset. */
module dsw_status_word_checker
    import dsw_pkg::*;
(
    input wire logic                sys_clk_i,
    input wire logic                rst_b_i,
    input wire logic                clk_en_i,
    input wire dsw_power_state_type power_state_i,
    input wire dsw_cond_type        cond_i,
    input wire logic [15:0]         speed_ref_i,
    input wire logic [15:0]         speed_act_i,
    input wire logic [15:0]         drive_status_word_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [15:0] w = drive_status_word_o;
    wire dsw_cond_type c = cond_i;
    // The edge that leaves reset still loads the reset word, so skip it
    wire logic go = rst_b_i && clk_en_i;
    wire logic run = power_state_i inside {DSW_PS_ENABLED, DSW_PS_QSTOP};
    wire logic on = run || power_state_i == DSW_PS_SWITCHED;
    wire logic rdy = on || power_state_i == DSW_PS_READY;
    wire logic flt = c.fault || power_state_i == DSW_PS_FAULT;
    wire logic sup = c.line_supply || c.power_stage_only;
    wire logic [1:0] dis_qs = {power_state_i == DSW_PS_DISABLED,
                               power_state_i != DSW_PS_QSTOP};
    wire logic [3:0] fl = {c.reverse, c.stop_key, c.network_ctrl, c.alarm};
    wire logic [3:0] wf = {w[15:14], w[9], w[7]};

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    state_bits_a: assert property (go |=> w[2:0] == $past({run, on, rdy}))
        else $error("state bits wrong");
    fault_bit_a: assert property (go |=> w[3] == $past(flt))
        else $error("fault bit wrong");
    supply_bit_a: assert property (go |=> w[4] == $past(sup))
        else $error("supply bit wrong");
    qstop_bit_a: assert property (go |=> w[6:5] == $past(dis_qs))
        else $error("quick stop or disabled bit wrong");
    flag_bits_a: assert property (go |=> wf == $past(fl))
        else $error("flag bits wrong");
    reached_bit_a: assert property (go |=> w[10] == $past(speed_act_i == speed_ref_i))
        else $error("reached bit wrong");
    reserved_zero_a: assert property (w[8] == 1'h0 && w[13:12] == 2'h0)
        else $error("reserved bits not zero");
    hold_word_a: assert property (!clk_en_i |=> $stable(w))
        else $error("word moved while disabled");

    cover property (w[2:0] == 3'h7 && !w[5]);
    cover property (w[11]);
    cover property (w[3] && w[15]);
endmodule

bind dsw_status_word dsw_status_word_checker i_chk (.sys_clk_i, .rst_b_i, .clk_en_i,
    .power_state_i, .cond_i, .speed_ref_i, .speed_act_i, .drive_status_word_o);

// >>> test/dsw_status_reader.sv
/* Far-side reader model: polls the status word every clock.
   Assumes the builder's clock and reset. */
module dsw_status_reader
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [15:0] word_i,
    output logic      [15:0] seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Polls only; it never drives the fault acknowledgement edge
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            seen_o <= 16'h0000;
        else
            seen_o <= word_i;
    end
endmodule

// >>> test/dsw_status_word_tb.sv
/* Self-checking bench of the status word builder over AXI4-Lite.
   Assumes the checker is bound and the reader model is present. */
`include "dsw_defs.svh"
module dsw_status_word_tb
    import dsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'h0, rst_b_i = 1'h0, clk_en_i = 1'h1, sm = 1'h1, io_profile_o;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_awready;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [15:0] speed_ref_i = 16'h0, speed_act_i = 16'h0, lo = 16'h0, hi = 16'hFFFF;
    logic [15:0] drive_status_word_o, seen_o;
    dsw_power_state_type power_state_i = DSW_PS_DISABLED;
    dsw_cond_type cond_i = 7'h00;
    dsw_power_state_type ps_tab[7] = '{DSW_PS_DISABLED, DSW_PS_READY, DSW_PS_SWITCHED,
        DSW_PS_ENABLED, DSW_PS_QSTOP, DSW_PS_FAULT, DSW_PS_NOT_READY};
    int bad_count = 0, n_compared = 0, cyc = 0;

    dsw_status_word i_dut (.sys_clk_i, .rst_b_i, .clk_en_i, .power_state_i, .cond_i,
        .speed_ref_i, .speed_act_i, .drive_status_word_o, .io_profile_o, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dsw_status_reader i_reader (.sys_clk_i, .rst_b_i, .word_i(drive_status_word_o), .seen_o);

    initial
    begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_b(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [15:0] exp_w();
        logic [15:0] e;
        dsw_power_state_type p;
        p = power_state_i;
        e = 16'h0000;
        e[2] = p inside {DSW_PS_ENABLED, DSW_PS_QSTOP};
        e[1] = e[2] || p == DSW_PS_SWITCHED;
        e[0] = e[1] || p == DSW_PS_READY;
        e[6:3] = {p == DSW_PS_DISABLED, p != DSW_PS_QSTOP,
            cond_i.line_supply | cond_i.power_stage_only, p == DSW_PS_FAULT || cond_i.fault};
        {e[15:14], e[9], e[7]} = {cond_i.reverse, cond_i.stop_key,
            cond_i.network_ctrl, cond_i.alarm};
        e[10] = speed_act_i == speed_ref_i;
        e[11] = sm && (speed_ref_i < lo || speed_ref_i > hi);
        return e;
    endfunction

    task automatic step();
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge sys_clk_i);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge sys_clk_i);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`DSW_ADDR_CONTROL, d, r);
        chk_b("control reset", 32'h2, d);
        axi_rd(`DSW_ADDR_HIGH_SPEED, d, r);
        chk_b("high limit reset", 32'hFFFF, d);
        axi_rd(12'h020, d, r);
        chk_b("unmapped resp", 32'h2, {30'h0, r});
        axi_wr(`DSW_ADDR_STATUS, 32'hFFFF, r);
        chk_b("read-only write resp", 32'h0, {30'h0, r});
        axi_wr(12'h020, 32'h0, r);
        chk_b("unmapped write resp", 32'h2, {30'h0, r});
        axi_rd(`DSW_ADDR_STATUS, d, r);
        chk_b("read-only word", {16'h0, exp_w()}, d);
        $display("t_regs done");
    endtask

    task automatic t_states(input logic prof);
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`DSW_ADDR_CONTROL, {30'h0, 1'h1, prof}, r);
        for (int i = 0; i < 14; i++)
        begin
            @(posedge sys_clk_i);
            power_state_i <= ps_tab[i % 7];
            cond_i.fault <= i >= 7;
            step();
            chk_w("state word", exp_w(), drive_status_word_o);
        end
        chk_b("profile", {31'h0, prof}, {31'h0, io_profile_o});
        axi_rd(`DSW_ADDR_STATUS, d, r);
        chk_b("bus word", {16'h0, exp_w()}, d);
        chk_w("reader word", exp_w(), seen_o);
        $display("t_states done");
    endtask

    task automatic t_flags();
        logic [15:0] w;
        for (int i = 0; i < 7; i++)
        begin
            @(posedge sys_clk_i);
            cond_i <= 7'h01 << i;
            step();
            chk_w("flag word", exp_w(), drive_status_word_o);
        end
        w = exp_w();
        @(posedge sys_clk_i);
        clk_en_i <= 1'h0;
        cond_i <= 7'h7F;
        step();
        chk_w("frozen word", w, drive_status_word_o);
        @(posedge sys_clk_i);
        clk_en_i <= 1'h1;
        step();
        chk_w("thawed word", exp_w(), drive_status_word_o);
        $display("t_flags done");
    endtask

    task automatic t_limit();
        logic [15:0] refs[4] = '{16'h00FF, 16'h0100, 16'h0200, 16'h0201};
        logic [1:0] r;
        axi_wr(`DSW_ADDR_LOW_SPEED, 32'h0100, r);
        axi_wr(`DSW_ADDR_HIGH_SPEED, 32'h0200, r);
        lo = 16'h0100;
        hi = 16'h0200;
        for (int m = 1; m >= 0; m--)
        begin
            axi_wr(`DSW_ADDR_CONTROL, 32'(m << 1), r);
            sm = m[0];
            foreach (refs[i])
            begin
                @(posedge sys_clk_i);
                speed_ref_i <= refs[i];
                speed_act_i <= 16'h0200;
                step();
                chk_w("limit word", exp_w(), drive_status_word_o);
            end
        end
        $display("t_limit done");
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'h1;
        t_regs();
        t_states(1'h0);
        t_states(1'h1);
        t_flags();
        t_limit();
        stop_test();
    end
endmodule
